// ===== hdl/link_param_config_regs.sv
// Purpose: Paged link parameter register bank with deskew status and interrupt, on Avalon-MM.
// Assumes: Lane deskew inputs are synchronous to clk; single clock domain.
// Notes: Each access is answered one cycle after it is presented.
//
// Function
// - An 8-bit read/write converter count less one resets to one.
// - Two read-only control-bit fields at bits 7:6 and 4:0 always read zero.
// - A 5-bit read/write resolution less one at bits 4:0 resets to fifteen.
// - A 3-bit read/write subclass at bits 7:5 resets to zero, with 0 and 1 as subclasses.
// - A 5-bit read/write sample width less one at bits 4:0 resets to fifteen.
// - A 3-bit read/write standard version at bits 7:5 resets to zero, 0 and 1 as revisions.
// - A 5-bit read/write samples per frame less one resets to one.
// - A read-only high density flag at bit 7 always reads one.
// - Two 8-bit read/write spare fields reset to zero and have no other effect.
// - An 8-bit read/write configuration checksum resets to zero.
// - Lanes 7 and 6 deskew status read at bits 7 and 6, one meaning achieved, reset zero.
// - Every register listed here is accessed in the copy of the link chosen by the page control; the page, soft reset and interrupt mask registers are shared.
// - Lanes 5 down to 0 deskew status read at bits 5 down to 0 with the same encoding.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module link_param_config_regs
    import link_param_pkg::*;
#(
    parameter int NUM_LINKS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NUM_LINKS-1:0][LANES-1:0] lane_deskew_ok,
    output link_cfg_t [NUM_LINKS-1:0] link_cfg,
    output logic deskew_block_soft_reset,
    output logic irq
);
    localparam int PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

    // A power of two keeps every page value backed by a real link copy.
    if (NUM_LINKS < 2 || NUM_LINKS > 8 || (NUM_LINKS & (NUM_LINKS - 1)) != 0) begin : g_chk
        $error("NUM_LINKS must be a power of two from 2 to 8");
    end

    typedef struct packed {
        bus_phase_t phase;
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
        logic [PAGE_W-1:0] link_page;
        logic soft_reset;
        logic irq;
        link_cfg_t [NUM_LINKS-1:0] cfg;
        logic [NUM_LINKS-1:0][LANES-1:0] deskew_seen;
        logic [NUM_LINKS-1:0][LANES-1:0] irq_status;
        logic [LANES-1:0] irq_mask;
    } state_t;

    localparam state_t ST_RESET = '{
        phase: PH_IDLE,
        waitrequest: 1'b1,
        readdata: '0,
        link_page: '0,
        soft_reset: SOFT_RST_INIT,
        irq: 1'b0,
        cfg: {NUM_LINKS{CFG_RESET}},
        deskew_seen: '0,
        irq_status: '0,
        irq_mask: '0
    };

    function automatic reg_sel_t decode(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_LINK_PAGE: decode = SEL_PAGE;
            IDX_CONV: decode = SEL_CONV;
            IDX_CTRL_RES: decode = SEL_CTRL_RES;
            IDX_SUBCLASS: decode = SEL_SUBCLASS;
            IDX_VERSION: decode = SEL_VERSION;
            IDX_DENSITY: decode = SEL_DENSITY;
            IDX_SPARE1: decode = SEL_SPARE1;
            IDX_SPARE2: decode = SEL_SPARE2;
            IDX_CHECKSUM: decode = SEL_CHECKSUM;
            IDX_DESKEW: decode = SEL_DESKEW;
            IDX_SOFT_RST: decode = SEL_SOFT_RST;
            IDX_IRQ_STATUS: decode = SEL_IRQ_STATUS;
            IDX_IRQ_MASK: decode = SEL_IRQ_MASK;
            default: decode = SEL_NONE;
        endcase
    endfunction

    state_t st_reg;
    state_t st_next;
    reg_sel_t sel;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;
    logic [LANES-1:0] clr_bits;
    link_cfg_t cur;

    always_comb begin
        st_next = st_reg;
        sel = decode(avs_address[ADDR_W-1:2]);
        cur = st_reg.cfg[st_reg.link_page];
        wr_byte = avs_writedata[7:0];
        clr_bits = '0;
        rd_byte = 8'h00;
        case (sel)
            SEL_PAGE: rd_byte = 8'(st_reg.link_page);
            SEL_CONV: rd_byte = cur.converter_count;
            SEL_CTRL_RES: rd_byte = {CS_VALUE, 1'b0, cur.resolution_less_one};
            SEL_SUBCLASS: rd_byte = {cur.device_subclass, cur.sample_width_less_one};
            SEL_VERSION: rd_byte = {cur.link_standard_version, cur.samples_less_one};
            SEL_DENSITY: rd_byte = {HD_VALUE, 2'b00, CF_VALUE};
            SEL_SPARE1: rd_byte = cur.spare_field_one;
            SEL_SPARE2: rd_byte = cur.spare_field_two;
            SEL_CHECKSUM: rd_byte = cur.config_checksum;
            SEL_DESKEW: rd_byte = st_reg.deskew_seen[st_reg.link_page];
            SEL_SOFT_RST: rd_byte = 8'(st_reg.soft_reset) << SOFT_RST_BIT;
            SEL_IRQ_STATUS: rd_byte = st_reg.irq_status[st_reg.link_page];
            SEL_IRQ_MASK: rd_byte = st_reg.irq_mask;
            default: rd_byte = 8'h00;
        endcase
        case (st_reg.phase)
            PH_IDLE: begin
                if (avs_read || avs_write) begin
                    st_next.phase = PH_ACK;
                    st_next.waitrequest = 1'b0;
                    if (avs_read) begin
                        st_next.readdata = {24'h000000, rd_byte};
                    end
                end
            end
            PH_ACK: begin
                st_next.phase = PH_IDLE;
                st_next.waitrequest = 1'b1;
                // The write lands on the same edge at which the master sees waitrequest low.
                if (avs_write && avs_byteenable[0]) begin
                    case (sel)
                        SEL_PAGE: st_next.link_page = wr_byte[PAGE_W-1:0];
                        SEL_CONV: st_next.cfg[st_reg.link_page].converter_count = wr_byte;
                        SEL_CTRL_RES: begin
                            st_next.cfg[st_reg.link_page].resolution_less_one =
                                wr_byte[LO_W-1:0];
                        end
                        SEL_SUBCLASS: begin
                            st_next.cfg[st_reg.link_page].device_subclass =
                                wr_byte[HI_LSB +: HI_W];
                            st_next.cfg[st_reg.link_page].sample_width_less_one =
                                wr_byte[LO_W-1:0];
                        end
                        SEL_VERSION: begin
                            st_next.cfg[st_reg.link_page].link_standard_version =
                                wr_byte[HI_LSB +: HI_W];
                            st_next.cfg[st_reg.link_page].samples_less_one =
                                wr_byte[LO_W-1:0];
                        end
                        SEL_SPARE1: st_next.cfg[st_reg.link_page].spare_field_one = wr_byte;
                        SEL_SPARE2: st_next.cfg[st_reg.link_page].spare_field_two = wr_byte;
                        // Software is trusted to change this only under soft reset.
                        SEL_CHECKSUM: begin
                            st_next.cfg[st_reg.link_page].config_checksum = wr_byte;
                        end
                        SEL_SOFT_RST: st_next.soft_reset = wr_byte[SOFT_RST_BIT];
                        SEL_IRQ_STATUS: clr_bits = wr_byte;
                        SEL_IRQ_MASK: st_next.irq_mask = wr_byte;
                        default: st_next.link_page = st_reg.link_page;
                    endcase
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
                st_next.waitrequest = 1'b1;
            end
        endcase
        // A lane losing deskew sets its sticky bit; the set wins over a same-cycle clear.
        st_next.irq = 1'b0;
        for (int l = 0; l < NUM_LINKS; l++) begin
            st_next.deskew_seen[l] = lane_deskew_ok[l];
            if (PAGE_W'(l) == st_reg.link_page) begin
                st_next.irq_status[l] = st_reg.irq_status[l] & ~clr_bits;
            end
            st_next.irq_status[l] = st_next.irq_status[l]
                | (st_reg.deskew_seen[l] & ~lane_deskew_ok[l]);
            st_next.irq = st_next.irq | (|(st_next.irq_status[l] & st_next.irq_mask));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata = st_reg.readdata;
    assign avs_waitrequest = st_reg.waitrequest;
    assign link_cfg = st_reg.cfg;
    assign deskew_block_soft_reset = st_reg.soft_reset;
    assign irq = st_reg.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic wr_hit;
    logic rd_req;
    assign wr_hit = st_reg.phase == PH_ACK && avs_write && avs_byteenable[0];
    assign rd_req = st_reg.phase == PH_IDLE && avs_read;

    chk_conv_write: assert property (wr_hit && sel == SEL_CONV |=>
        link_cfg[$past(st_reg.link_page)].converter_count == $past(avs_writedata[7:0]))
        else $error("converter count write not stored");
    chk_ctrl_zero: assert property (rd_req && sel == SEL_CTRL_RES |=>
        avs_readdata[7:5] == 3'b000 && avs_readdata[31:8] == 24'h000000)
        else $error("control bit field not zero");
    chk_res_write: assert property (wr_hit && sel == SEL_CTRL_RES |=>
        link_cfg[$past(st_reg.link_page)].resolution_less_one == $past(avs_writedata[4:0]))
        else $error("resolution write not stored");
    chk_subclass_write: assert property (wr_hit && sel == SEL_SUBCLASS |=>
        link_cfg[$past(st_reg.link_page)].device_subclass == $past(avs_writedata[7:5]))
        else $error("subclass write not stored");
    chk_version_write: assert property (wr_hit && sel == SEL_VERSION |=>
        link_cfg[$past(st_reg.link_page)].link_standard_version == $past(avs_writedata[7:5]))
        else $error("version write not stored");
    chk_density_read: assert property (rd_req && sel == SEL_DENSITY |=>
        avs_readdata == 32'h00000080)
        else $error("density register read wrong");
    chk_checksum_write: assert property (wr_hit && sel == SEL_CHECKSUM |=>
        link_cfg[$past(st_reg.link_page)].config_checksum == $past(avs_writedata[7:0]))
        else $error("checksum write not stored");
    chk_deskew_read: assert property (rd_req && sel == SEL_DESKEW |=>
        avs_readdata[7:0] == $past(st_reg.deskew_seen[st_reg.link_page]))
        else $error("deskew status read wrong");
    chk_paged_read: assert property (rd_req && sel == SEL_CONV |=>
        avs_readdata[7:0] == link_cfg[st_reg.link_page].converter_count)
        else $error("paged read returned another link");
    chk_bus_answer: assert property ((avs_read || avs_write) && st_reg.phase == PH_IDLE |=>
        !avs_waitrequest ##1 avs_waitrequest)
        else $error("answer not one cycle after request");

    chk_width_write: assert property (wr_hit && sel == SEL_SUBCLASS |=>
        link_cfg[$past(st_reg.link_page)].sample_width_less_one == $past(avs_writedata[4:0]))
        else $error("sample width write not stored");

    chk_samples_write: assert property (wr_hit && sel == SEL_VERSION |=>
        link_cfg[$past(st_reg.link_page)].samples_less_one == $past(avs_writedata[4:0]))
        else $error("samples per frame write not stored");

    chk_spare_one: assert property (wr_hit && sel == SEL_SPARE1 |=>
        link_cfg[$past(st_reg.link_page)].spare_field_one == $past(avs_writedata[7:0]))
        else $error("first spare write not stored");

    chk_spare_two: assert property (wr_hit && sel == SEL_SPARE2 |=>
        link_cfg[$past(st_reg.link_page)].spare_field_two == $past(avs_writedata[7:0]))
        else $error("second spare write not stored");

    chk_cf_zero: assert property (rd_req && sel == SEL_DENSITY |=>
        avs_readdata[4:0] == 5'h00)
        else $error("control words field not zero");

    chk_hd_flag: assert property (rd_req && sel == SEL_DENSITY |=>
        avs_readdata[HD_BIT] == 1'b1)
        else $error("high density flag not set");

    chk_res_read: assert property (rd_req && sel == SEL_CTRL_RES |=>
        avs_readdata[4:0] == $past(cur.resolution_less_one))
        else $error("resolution read wrong");

    chk_subclass_read: assert property (rd_req && sel == SEL_SUBCLASS |=>
        avs_readdata[7:0] == $past({cur.device_subclass, cur.sample_width_less_one}))
        else $error("subclass register read wrong");

    chk_version_read: assert property (rd_req && sel == SEL_VERSION |=>
        avs_readdata[7:0] == $past({cur.link_standard_version, cur.samples_less_one}))
        else $error("version register read wrong");

    chk_checksum_read: assert property (rd_req && sel == SEL_CHECKSUM |=>
        avs_readdata[7:0] == $past(cur.config_checksum))
        else $error("checksum read wrong");

    chk_spare_read: assert property (rd_req && sel == SEL_SPARE1 |=>
        avs_readdata[7:0] == $past(cur.spare_field_one))
        else $error("spare read wrong");

    chk_upper_zero: assert property (rd_req |=>
        avs_readdata[DATA_W-1:8] == '0)
        else $error("upper read data bits not zero");

    chk_unmapped_read: assert property (rd_req && sel == SEL_NONE |=>
        avs_readdata == '0)
        else $error("unmapped register read not zero");

    chk_page_write: assert property (wr_hit && sel == SEL_PAGE |=>
        st_reg.link_page == $past(avs_writedata[PAGE_W-1:0]))
        else $error("link page write not stored");

    chk_page_isolate: assert property (wr_hit && st_reg.link_page != '0 |=>
        link_cfg[0] == $past(link_cfg[0]))
        else $error("write on another page changed link zero");

    chk_be_ignore: assert property (st_reg.phase == PH_ACK && avs_write && !avs_byteenable[0]
        |=> link_cfg == $past(link_cfg))
        else $error("write without byte lane zero changed a register");

    chk_read_keeps: assert property (rd_req |=> link_cfg == $past(link_cfg))
        else $error("read changed stored configuration");

    chk_soft_write: assert property (wr_hit && sel == SEL_SOFT_RST |=>
        deskew_block_soft_reset == $past(avs_writedata[SOFT_RST_BIT]))
        else $error("soft reset write not stored");

    chk_mask_write: assert property (wr_hit && sel == SEL_IRQ_MASK |=>
        st_reg.irq_mask == $past(avs_writedata[LANES-1:0]))
        else $error("interrupt mask write not stored");

    chk_wait_idle: assert property (st_reg.phase == PH_IDLE |-> avs_waitrequest)
        else $error("waitrequest low outside the answer cycle");

    chk_deskew_follow: assert property ($past(rst_n) |->
        st_reg.deskew_seen == $past(lane_deskew_ok))
        else $error("deskew status lags its lanes");

    logic [NUM_LINKS-1:0] irq_link;
    logic [NUM_LINKS-1:0][LANES-1:0] lane_lost;

    // Per-link event and clear checks; the set must win over a same-cycle clear.
    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_link
        assign irq_link[g] = |(st_reg.irq_status[g] & st_reg.irq_mask);
        assign lane_lost[g] = st_reg.deskew_seen[g] & ~lane_deskew_ok[g];

        chk_lost_sets: assert property (lane_lost[g] != '0 |=>
            (st_reg.irq_status[g] & $past(lane_lost[g])) == $past(lane_lost[g]))
            else $error("lost deskew did not set its status bit");

        chk_clear_works: assert property (wr_hit && sel == SEL_IRQ_STATUS
            && st_reg.link_page == PAGE_W'(g) && lane_lost[g] == '0 |=>
            (st_reg.irq_status[g] & $past(avs_writedata[LANES-1:0])) == '0)
            else $error("status bit not cleared by a written one");
    end

    chk_irq_level: assert property (irq == |irq_link)
        else $error("interrupt does not follow masked status");
endmodule

`default_nettype wire

// ===== shared/link_param_pkg.sv
// Purpose: Constants, register map and carrier types for the link parameter register bank.
// Assumes: Registers sit in byte lane 0 of 32-bit Avalon words; byte address is four times the index.
// Notes: Upper bits of every register word read as zero.
package link_param_pkg;
    localparam int ADDR_W = 13;
    localparam int IDX_W = 11;
    localparam int DATA_W = 32;
    localparam int LANES = 8;
    localparam int HI_LSB = 5;
    localparam int HI_W = 3;
    localparam int LO_W = 5;
    localparam int CS_LSB = 6;
    localparam int HD_BIT = 7;
    localparam int SOFT_RST_BIT = 3;

    localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 11'h300;
    localparam logic [IDX_W-1:0] IDX_CONV = 11'h456;
    localparam logic [IDX_W-1:0] IDX_CTRL_RES = 11'h457;
    localparam logic [IDX_W-1:0] IDX_SUBCLASS = 11'h458;
    localparam logic [IDX_W-1:0] IDX_VERSION = 11'h459;
    localparam logic [IDX_W-1:0] IDX_DENSITY = 11'h45a;
    localparam logic [IDX_W-1:0] IDX_SPARE1 = 11'h45b;
    localparam logic [IDX_W-1:0] IDX_SPARE2 = 11'h45c;
    localparam logic [IDX_W-1:0] IDX_CHECKSUM = 11'h45d;
    localparam logic [IDX_W-1:0] IDX_DESKEW = 11'h46c;
    localparam logic [IDX_W-1:0] IDX_SOFT_RST = 11'h475;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 11'h480;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 11'h481;

    localparam logic [1:0] CS_VALUE = 2'h0;
    localparam logic [4:0] CF_VALUE = 5'h00;
    localparam logic HD_VALUE = 1'b1;
    localparam logic SOFT_RST_INIT = 1'b0;

    typedef struct packed {
        logic [7:0] converter_count;
        logic [4:0] resolution_less_one;
        logic [2:0] device_subclass;
        logic [4:0] sample_width_less_one;
        logic [2:0] link_standard_version;
        logic [4:0] samples_less_one;
        logic [7:0] spare_field_one;
        logic [7:0] spare_field_two;
        logic [7:0] config_checksum;
    } link_cfg_t;

    localparam link_cfg_t CFG_RESET = '{
        converter_count: 8'h01,
        resolution_less_one: 5'h0f,
        device_subclass: 3'h0,
        sample_width_less_one: 5'h0f,
        link_standard_version: 3'h0,
        samples_less_one: 5'h01,
        spare_field_one: 8'h00,
        spare_field_two: 8'h00,
        config_checksum: 8'h00
    };

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ACK = 2'b01
    } bus_phase_t;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_PAGE, SEL_CONV, SEL_CTRL_RES, SEL_SUBCLASS, SEL_VERSION, SEL_DENSITY,
        SEL_SPARE1, SEL_SPARE2, SEL_CHECKSUM, SEL_DESKEW, SEL_SOFT_RST, SEL_IRQ_STATUS,
        SEL_IRQ_MASK
    } reg_sel_t;
endpackage

// ===== test/lane_source_model.sv
// Purpose: Far-side transmitter model driving per-lane deskew results for each link.
// Assumes: Synchronous to clk; lanes head toward the pattern the bench asks for.
// Notes: Loss is immediate and gain is delayed, as alignment only completes after a settle time.
`timescale 1ns/1ps
`default_nettype none

module lane_source_model
    import link_param_pkg::*;
#(
    parameter int NUM_LINKS = 2,
    parameter int ALIGN_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_LINKS-1:0][LANES-1:0] target,
    output logic [NUM_LINKS-1:0][LANES-1:0] lane_deskew_ok
);
    int cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_deskew_ok <= '0;
            cnt <= 0;
        end else begin
            lane_deskew_ok <= lane_deskew_ok & target;
            if ((target & ~lane_deskew_ok) != '0) begin
                cnt <= cnt + 1;
                if (cnt == ALIGN_CYCLES) begin
                    lane_deskew_ok <= target;
                    cnt <= 0;
                end
            end else begin
                cnt <= 0;
            end
        end
    end
endmodule

`default_nettype wire

// ===== test/test_link_param_config_regs.sv
// Purpose: Self-checking bench for the paged link parameter register bank.
// Assumes: Avalon answers after one cycle; the bench still waits on waitrequest.
// Notes: Two links; lane results come from the transmitter model.
`timescale 1ns/1ps
`default_nettype none

module test_link_param_config_regs
    import link_param_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0][LANES-1:0] target = '0;
    logic [1:0][LANES-1:0] lane_deskew_ok;
    link_cfg_t [1:0] link_cfg;
    logic deskew_block_soft_reset;
    logic irq;
    int err_count = 0;
    int check_count = 0;
    logic [IDX_W-1:0] idx_tab [9] = '{IDX_CONV, IDX_CTRL_RES, IDX_SUBCLASS, IDX_VERSION,
        IDX_DENSITY, IDX_SPARE1, IDX_SPARE2, IDX_CHECKSUM, IDX_DESKEW};
    logic [7:0] rst_tab [9] = '{8'h01, 8'h0f, 8'h0f, 8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wr_tab [9] = '{8'ha5, 8'hff, 8'h2b, 8'h23, 8'h00, 8'h5a, 8'hc3, 8'h9e, 8'hff};
    logic [7:0] rd_tab [9] = '{8'ha5, 8'h1f, 8'h2b, 8'h23, 8'h80, 8'h5a, 8'hc3, 8'h9e, 8'h00};

    always #2.5 clk = ~clk;

    link_param_config_regs #(.NUM_LINKS(2)) DUT (.clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .lane_deskew_ok(lane_deskew_ok), .link_cfg(link_cfg),
        .deskew_block_soft_reset(deskew_block_soft_reset), .irq(irq));

    lane_source_model #(.NUM_LINKS(2)) far_end (.clk(clk), .rst_n(rst_n), .target(target),
        .lane_deskew_ok(lane_deskew_ok));

    task automatic end_sim;
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One bus cycle: held until waitrequest is sampled low, read data taken at that edge.
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            err_count++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, 4'hf, q);
    endtask

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 4'hf, q);
        check(q, {24'h0, e});
    endtask

    task automatic defaults_on(input logic [7:0] page);
        wr(IDX_LINK_PAGE, page);
        for (int i = 0; i < 9; i++)
            rd_chk(idx_tab[i], rst_tab[i]);
    endtask

    // Page 1 is rewritten; page 0 must keep its reset copy.
    task automatic paged_write;
        logic [31:0] q;
        wr(IDX_SOFT_RST, 8'h08);
        wr(IDX_LINK_PAGE, 8'h01);
        rd_chk(IDX_LINK_PAGE, 8'h01);
        for (int i = 0; i < 9; i++)
            wr(idx_tab[i], wr_tab[i]);
        wr(IDX_SOFT_RST, 8'h00);
        for (int i = 0; i < 9; i++)
            rd_chk(idx_tab[i], rd_tab[i]);
        bus(1'b1, IDX_SPARE1, 8'h11, 4'he, q);
        rd_chk(IDX_SPARE1, 8'h5a);
        check(link_cfg[1].converter_count, 8'ha5);
        check(link_cfg[1].device_subclass, 3'h1);
        check(link_cfg[1].link_standard_version, 3'h1);
        check(32'(link_cfg[0] >> 32), 32'(CFG_RESET >> 32));
        check(32'(link_cfg[0]), 32'(CFG_RESET));
        wr(11'h123, 8'h77);
        rd_chk(11'h123, 8'h00);
        defaults_on(8'h00);
    endtask

    // Checksum is loaded with the deskew block held in soft reset.
    task automatic checksum_load;
        wr(IDX_SOFT_RST, 8'h08);
        rd_chk(IDX_SOFT_RST, 8'h08);
        check(deskew_block_soft_reset, 1'b1);
        wr(IDX_CHECKSUM, 8'h3c);
        rd_chk(IDX_CHECKSUM, 8'h3c);
        wr(IDX_SOFT_RST, 8'h00);
        @(posedge clk);
        check(deskew_block_soft_reset, 1'b0);
    endtask

    task automatic deskew_irq;
        target[1] <= 8'hc5;
        repeat (10) @(posedge clk);
        wr(IDX_LINK_PAGE, 8'h01);
        rd_chk(IDX_DESKEW, 8'hc5);
        wr(IDX_IRQ_MASK, 8'h04);
        rd_chk(IDX_IRQ_MASK, 8'h04);
        target[1] <= 8'hc1;
        repeat (4) @(posedge clk);
        check(irq, 1'b1);
        rd_chk(IDX_IRQ_STATUS, 8'h04);
        wr(IDX_IRQ_STATUS, 8'h04);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        target[1] <= 8'hc0;
        repeat (4) @(posedge clk);
        check(irq, 1'b0);
        rd_chk(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_STATUS, 8'h01);
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        wr(IDX_LINK_PAGE, 8'h00);
        rd_chk(IDX_DESKEW, 8'h00);
    endtask

    // A reset in mid-run must bring back every stored value on every page.
    task automatic reset_again;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check(irq, 1'b0);
        check(32'(link_cfg[1] >> 32), 32'(CFG_RESET >> 32));
        check(32'(link_cfg[1]), 32'(CFG_RESET));
        check(deskew_block_soft_reset, 1'b0);
        defaults_on(8'h00);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        check(irq, 1'b0);
        defaults_on(8'h01);
        defaults_on(8'h00);
        paged_write();
        checksum_load();
        deskew_irq();
        reset_again();
        end_sim();
    end
endmodule

`default_nettype wire
